/* pkg/frwp_defines.vh */
`ifndef FRWP_DEFINES_VH
`define FRWP_DEFINES_VH

// Command codes
`define FRWP_CMD_READ_ARRAY   8'hFF
`define FRWP_CMD_READ_STATUS  8'h70
`define FRWP_CMD_CLEAR_STATUS 8'h50
`define FRWP_CMD_WRITE_SETUP  8'h40
`define FRWP_CMD_ERASE_SETUP  8'h20
`define FRWP_CMD_LOCK_SETUP   8'h60
`define FRWP_CMD_CONFIRM      8'hD0

// Operation kinds on OP_KIND
`define FRWP_OP_WRITE  2'h0
`define FRWP_OP_ERASE  2'h1
`define FRWP_OP_LOCK   2'h2
`define FRWP_OP_READ   2'h3

// Status bit positions
`define FRWP_SR_READY        7
`define FRWP_SR_ERASE_ERR    5
`define FRWP_SR_WRITE_ERR    4
`define FRWP_SR_SUPPLY_ERR   3

// Timing in ns and in 20 ns cycles
`define FRWP_CLK_NS              20
`define FRWP_WE_PULSE_NS         60
`define FRWP_WE_PULSE_CYC        ((`FRWP_WE_PULSE_NS + `FRWP_CLK_NS - 1) / `FRWP_CLK_NS)
`define FRWP_RESET_TO_READ_NS    400
`define FRWP_RESET_TO_READ_CYC   ((`FRWP_RESET_TO_READ_NS + `FRWP_CLK_NS - 1) / `FRWP_CLK_NS)
`define FRWP_RESET_TO_WRITE_NS   1000
`define FRWP_RESET_TO_WRITE_CYC  ((`FRWP_RESET_TO_WRITE_NS + `FRWP_CLK_NS - 1) / `FRWP_CLK_NS)
`define FRWP_READ_ACCESS_NS      120
`define FRWP_READ_ACCESS_CYC     ((`FRWP_READ_ACCESS_NS + `FRWP_CLK_NS - 1) / `FRWP_CLK_NS)

`endif

/* hdl/frwp_host.v */
// Document rules this block follows or relies on
// RULE1 - Device flags supply error plus write or erase error on supply fault.
// RULE2 - Busy output stays low through internal reset after reset pin drops.
// RULE3 - Device aborts interrupted operation, enters deep power-down.
// RULE4 - Host repeats whole command sequence of any operation aborted by reset; this block does not repeat it, the caller reissues.
// RULE5 - Device clears status on power-off and reset pin low.
// RULE6 - Command interface keeps latched command across supply and enable changes.
// RULE7 - Command interface enters read-array at power-up and deep power-down exit.
// RULE8 - Host writes read-array command after each data-altering operation completes.
// RULE9 - Writes happen only with write and chip enable both low.
// RULE10 - Data-altering operations use setup write then confirm write.
// RULE11 - Device ignores controls while reset pin is low.
// RULE12 - Host waits wake-up intervals after raising reset pin.
// RULE13 - Busy output low from accepted command until algorithm finishes.
// RULE14 - Read-array command returns device to read-array; host writes it last.
// RULE15 - Supply error or reset abort leaves state machine idle and ready.
`timescale 1ns/1ps
`include "frwp_defines.vh"

module frwp_host (
    // Clock and reset
    input  wire        CLK,
    input  wire        RST,
    // User request
    input  wire        REQ_VALID,
    input  wire [1:0]  OP_KIND,
    input  wire [19:0] REQ_ADDR,
    input  wire [7:0]  REQ_DATA,
    input  wire        PD_REQ,
    output reg         REQ_READY,
    output reg         DONE,
    output reg  [7:0]  RESULT,
    output reg         ERR_SUPPLY,
    output reg         ERR_OP,
    output reg         ABORTED,
    // Flash pins
    output reg  [19:0] FL_ADDR,
    input  wire [7:0]  FL_DQ_IN,
    output reg  [7:0]  FL_DQ_OUT,
    output reg         FL_DQ_OE_N,
    output reg         FL_CE_N,
    output reg         FL_WE_N,
    output reg         FL_OE_N,
    output reg         FL_RP_N,
    input  wire        FL_READY_BUSY_N_OUT_N
);

    localparam [10:0] S_WAKE   = 11'h001;
    localparam [10:0] S_IDLE   = 11'h002;
    localparam [10:0] S_WSET   = 11'h004;
    localparam [10:0] S_WGAP   = 11'h008;
    localparam [10:0] S_WREL   = 11'h010;
    localparam [10:0] S_POLL   = 11'h020;
    localparam [10:0] S_STAT   = 11'h040;
    localparam [10:0] S_READ   = 11'h080;
    localparam [10:0] S_PDOWN  = 11'h200;
    localparam [10:0] S_FIN    = 11'h400;

    localparam [1:0] PH_SETUP = 2'h0;
    localparam [1:0] PH_CONF  = 2'h1;
    localparam [1:0] PH_RA    = 2'h2;
    localparam [1:0] PH_RS    = 2'h3;

    // Counts kept 32 bits wide, cut to the 16-bit counter on every load
    localparam [31:0] WE_CYC_W   = `FRWP_WE_PULSE_CYC;
    localparam [31:0] RD_CYC_W   = `FRWP_READ_ACCESS_CYC;
    localparam [31:0] WAKE_CYC_W = `FRWP_RESET_TO_WRITE_CYC;

    reg [10:0] state_q;
    reg [10:0] state_d;
    reg [15:0] cnt_q;
    reg [1:0]  phase_q;
    reg [1:0]  op_q;
    reg [7:0]  data_q;
    reg        busy_seen_q;
    reg        aborted_q;

    wire [7:0] setup_code = (op_q == `FRWP_OP_ERASE) ? `FRWP_CMD_ERASE_SETUP :
                            (op_q == `FRWP_OP_LOCK)  ? `FRWP_CMD_LOCK_SETUP  :
                                                       `FRWP_CMD_WRITE_SETUP;
    wire [7:0] conf_code  = (op_q == `FRWP_OP_WRITE) ? data_q : `FRWP_CMD_CONFIRM;
    wire [7:0] cmd_code   = (phase_q == PH_SETUP) ? setup_code :
                            (phase_q == PH_CONF)  ? conf_code  :
                            (phase_q == PH_RS)    ? `FRWP_CMD_READ_STATUS :
                                                    `FRWP_CMD_READ_ARRAY;
    wire       cnt_zero   = (cnt_q == 16'h0000);

    always @* begin
        state_d = state_q;
        case (state_q)
            S_WAKE:  if (cnt_zero) state_d = S_IDLE; // RULE12
            S_IDLE:  if (PD_REQ) state_d = S_PDOWN;
                     else if (REQ_VALID) state_d = (OP_KIND == `FRWP_OP_READ) ? S_READ : S_WSET;
            S_WSET:  if (cnt_zero) state_d = S_WREL;
            S_WREL:  if (cnt_zero) state_d = S_WGAP;
            S_WGAP:  begin
                if (phase_q == PH_SETUP) state_d = S_WSET; // RULE10
                else if (phase_q == PH_CONF) state_d = S_POLL;
                else if (phase_q == PH_RS) state_d = S_STAT;
                else if (op_q == `FRWP_OP_READ) state_d = S_READ;
                else state_d = S_FIN;
            end
            S_POLL:  if (busy_seen_q && FL_READY_BUSY_N_OUT_N) state_d = S_WSET; // RULE13
            S_STAT:  if (cnt_zero) state_d = S_WSET;
            S_READ:  if (cnt_zero) state_d = S_FIN;
            S_PDOWN: if (!PD_REQ) state_d = S_WAKE;
            S_FIN:   state_d = S_IDLE;
            default: state_d = S_WAKE;
        endcase
    end

    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_q     <= S_WAKE;
            cnt_q       <= WAKE_CYC_W[15:0];
            phase_q     <= PH_SETUP;
            op_q        <= 2'h0;
            data_q      <= 8'h00;
            busy_seen_q <= 1'b0;
            aborted_q   <= 1'b0;
            REQ_READY   <= 1'b0;
            DONE        <= 1'b0;
            RESULT      <= 8'h00;
            ERR_SUPPLY  <= 1'b0;
            ERR_OP      <= 1'b0;
            ABORTED     <= 1'b0;
            FL_ADDR     <= 20'h00000;
            FL_DQ_OUT   <= 8'hFF;
            FL_DQ_OE_N  <= 1'b1;
            FL_CE_N     <= 1'b1;
            FL_WE_N     <= 1'b1;
            FL_OE_N     <= 1'b1;
            FL_RP_N     <= 1'b0;
        end else begin
            state_q   <= state_d;
            DONE      <= 1'b0;
            REQ_READY <= (state_d == S_IDLE);
            if (!cnt_zero) cnt_q <= cnt_q - 16'h0001;
            case (state_q)
                S_WAKE: begin
                    FL_RP_N <= 1'b1;
                end
                S_IDLE: begin
                    if (PD_REQ) begin
                        // Pending operation sequence is lost; caller must reissue
                        FL_RP_N <= 1'b0; // RULE4
                    end else if (REQ_VALID) begin
                        op_q       <= OP_KIND;
                        data_q     <= REQ_DATA;
                        ERR_SUPPLY <= 1'b0;
                        ERR_OP     <= 1'b0;
                        ABORTED    <= 1'b0;
                        aborted_q  <= 1'b0;
                        FL_ADDR    <= REQ_ADDR;
                        if (OP_KIND == `FRWP_OP_READ) begin
                            FL_CE_N <= 1'b0;
                            FL_OE_N <= 1'b0;
                            cnt_q   <= RD_CYC_W[15:0];
                        end else begin
                            phase_q <= PH_SETUP;
                            cnt_q   <= WE_CYC_W[15:0];
                        end
                    end
                end
                S_WSET: begin
                    // Data driven in the same cycle the enables fall, both enables low together
                    FL_DQ_OUT  <= cmd_code;
                    FL_DQ_OE_N <= 1'b0;
                    FL_CE_N    <= 1'b0; // RULE9
                    FL_WE_N    <= 1'b0; // RULE9
                    if (cnt_zero) cnt_q <= WE_CYC_W[15:0];
                end
                S_WREL: begin
                    // WE raised first so the write latches with data still stable
                    FL_WE_N <= 1'b1; // RULE9
                    if (cnt_zero) begin
                        FL_CE_N    <= 1'b1;
                        FL_DQ_OE_N <= 1'b1;
                    end
                end
                S_WGAP: begin
                    cnt_q <= WE_CYC_W[15:0];
                    busy_seen_q <= 1'b0;
                    if (phase_q == PH_SETUP) phase_q <= PH_CONF;
                    else if (phase_q == PH_CONF) phase_q <= PH_RS;
                    else if (phase_q == PH_RS) begin
                        FL_CE_N <= 1'b0;
                        FL_OE_N <= 1'b0;
                        cnt_q   <= RD_CYC_W[15:0];
                    end
                end
                S_POLL: begin
                    if (!FL_READY_BUSY_N_OUT_N) busy_seen_q <= 1'b1; // RULE13
                    if (busy_seen_q && FL_READY_BUSY_N_OUT_N) cnt_q <= WE_CYC_W[15:0];
                end
                S_STAT: begin
                    if (cnt_zero) begin
                        RESULT     <= FL_DQ_IN;
                        ERR_SUPPLY <= FL_DQ_IN[`FRWP_SR_SUPPLY_ERR]; // RULE1
                        ERR_OP     <= FL_DQ_IN[`FRWP_SR_WRITE_ERR] |
                                      FL_DQ_IN[`FRWP_SR_ERASE_ERR]; // RULE1
                        FL_CE_N    <= 1'b1;
                        FL_OE_N    <= 1'b1;
                        // Read-array ends every altering operation
                        phase_q    <= PH_RA; // RULE8 RULE14
                        cnt_q      <= WE_CYC_W[15:0];
                    end
                end
                S_READ: begin
                    if (cnt_zero) begin
                        RESULT  <= FL_DQ_IN;
                        FL_CE_N <= 1'b1;
                        FL_OE_N <= 1'b1;
                    end
                end
                S_PDOWN: begin
                    FL_RP_N <= 1'b0;
                    FL_CE_N <= 1'b1;
                    FL_WE_N <= 1'b1;
                    FL_OE_N <= 1'b1;
                    FL_DQ_OE_N <= 1'b1;
                    if (!PD_REQ) begin
                        FL_RP_N <= 1'b1;
                        cnt_q   <= WAKE_CYC_W[15:0]; // RULE12
                    end
                end
                S_FIN: begin
                    DONE    <= 1'b1;
                    ABORTED <= aborted_q;
                end
                default: ;
            endcase
        end
    end

endmodule

/* dv/frwp_flash_model.sv */
`timescale 1ns/1ps
module frwp_flash_model (
    input  wire logic        clk, ce_n, we_n, oe_n, rp_n, vpp_ok,
    input  wire logic [19:0] addr,
    input  wire logic [7:0]  din, busy_len,
    output wire logic [7:0]  dout,
    output wire logic        ready_busy_n_out_n
);
    logic [7:0] mem [0:15];
    logic [7:0] sr_q, dq_q, last_q, setup_q;
    logic [3:0] a_q;
    logic       wr_q, stat_q;
    int         busy_q;
    wire rd = !ce_n && !oe_n && rp_n;
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        {sr_q, dq_q, last_q, setup_q, a_q, wr_q, stat_q, busy_q} = '0;
    end
    assign ready_busy_n_out_n = (busy_q == 0);
    // Released bus shows the inverse, so a stale sample is caught
    assign dout = !rd ? ~last_q : stat_q ? {ready_busy_n_out_n, sr_q[6:0]} : mem[addr[3:0]];
    always @(posedge clk) begin
        if (rd) last_q <= dout;
        wr_q <= !we_n && !ce_n && rp_n;
        if (!we_n) begin
            dq_q <= din;
            a_q  <= addr[3:0];
        end
        if (busy_q > 0) busy_q <= busy_q - 1;
        if (!rp_n) begin
            sr_q    <= 8'h00;
            stat_q  <= 1'b0;
            setup_q <= 8'h00;
            if (busy_q > 3) busy_q <= 3;
            // Cut write leaves the byte half done, so only a reissue restores it
            if (busy_q > 0) mem[a_q] <= dq_q | 8'hF0;
        end else if (wr_q && we_n) begin
            if (setup_q != 8'h00) begin
                stat_q  <= 1'b1;
                setup_q <= 8'h00;
                busy_q  <= busy_len;
                if (!vpp_ok) sr_q <= sr_q | (setup_q == 8'h40 ? 8'h18 : 8'h28);
                else if (setup_q == 8'h40) mem[a_q] <= dq_q;
                else if (setup_q == 8'h20) foreach (mem[i]) mem[i] <= 8'hFF;
            end else case (dq_q)
                8'hFF: stat_q <= 1'b0;
                8'h70: stat_q <= 1'b1;
                8'h50: sr_q <= 8'h00;
                default: setup_q <= dq_q;
            endcase
        end
    end
endmodule

/* dv/frwp_host_assertions.sv */
`timescale 1ns/1ps
module frwp_host_chk (
    input wire logic       CLK, RST, REQ_VALID, REQ_READY, DONE, FL_CE_N, FL_WE_N,
    input wire logic       FL_OE_N, FL_RP_N, FL_DQ_OE_N, FL_READY_BUSY_N_OUT_N,
    input wire logic [7:0] FL_DQ_OUT
);
    logic [5:0] wake_q;
    logic [7:0] last_q;
    logic [2:0] wr_q;
    logic       we_q;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            {wake_q, wr_q, we_q} <= {6'h00, 3'h0, 1'b1};
            last_q <= 8'hFF;
        end else begin
            we_q <= FL_WE_N;
            wake_q <= !FL_RP_N ? 6'h00 : (wake_q == 6'h3F ? wake_q : wake_q + 6'h01);
            if (!FL_WE_N) last_q <= FL_DQ_OUT;
            if (REQ_VALID && REQ_READY) wr_q <= 3'h0;
            else if (!FL_WE_N && we_q) wr_q <= wr_q + 3'h1;
        end
    end
    chk_we_with_ce: assert property (!FL_WE_N |-> !FL_CE_N) else $error("write without select");
    chk_we_not_oe: assert property (!FL_WE_N |-> FL_OE_N && !FL_DQ_OE_N) else $error("write clash");
    chk_rp_quiet: assert property (!FL_RP_N |-> FL_WE_N && FL_CE_N) else $error("active in reset");
    chk_wake_write: assert property (!FL_WE_N |-> wake_q >= 6'h32) else $error("early write");
    chk_wake_read: assert property (!FL_OE_N |-> wake_q >= 6'h14) else $error("early read");
    chk_last_cmd: assert property ($rose(DONE) |-> last_q == 8'hFF) else $error("no read array");
    chk_two_step: assert property (DONE |-> wr_q inside {3'h0, 3'h1, 3'h4}) else $error("bad count");
    chk_busy_hold: assert property (!FL_READY_BUSY_N_OUT_N && FL_RP_N |-> FL_WE_N) else $error("write busy");
    cover property ($rose(DONE));
    cover property ($fell(FL_RP_N));
    cover property (!FL_READY_BUSY_N_OUT_N && !FL_RP_N);
endmodule
bind frwp_host frwp_host_chk u_chk (.CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .DONE(DONE), .FL_CE_N(FL_CE_N), .FL_WE_N(FL_WE_N),
    .FL_OE_N(FL_OE_N), .FL_RP_N(FL_RP_N), .FL_DQ_OE_N(FL_DQ_OE_N),
    .FL_READY_BUSY_N_OUT_N(FL_READY_BUSY_N_OUT_N), .FL_DQ_OUT(FL_DQ_OUT));

/* dv/tb_frwp_host.sv */
`timescale 1ns/1ps
module tb_frwp_host;
    logic CLK = 0, RST = 1, REQ_VALID = 0, PD_REQ = 0, vpp_ok = 1;
    logic [1:0] OP_KIND = 0;
    logic [19:0] REQ_ADDR = 0;
    logic [7:0] REQ_DATA = 0, busy_len = 8'h0C;
    wire REQ_READY, DONE, ERR_SUPPLY, ERR_OP, FL_DQ_OE_N, FL_CE_N, FL_WE_N, FL_OE_N, FL_RP_N;
    wire FL_READY_BUSY_N_OUT_N, ABORTED;
    wire [7:0] RESULT, FL_DQ_OUT, fl_dout;
    wire [7:0] FL_DQ_IN = !FL_DQ_OE_N ? FL_DQ_OUT : fl_dout;
    wire [19:0] FL_ADDR;
    int error_cnt = 0, checks = 0, cyc = 0;
    frwp_host DUT (.CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID), .OP_KIND(OP_KIND),
        .REQ_ADDR(REQ_ADDR), .REQ_DATA(REQ_DATA), .PD_REQ(PD_REQ), .REQ_READY(REQ_READY),
        .DONE(DONE), .RESULT(RESULT), .ERR_SUPPLY(ERR_SUPPLY), .ERR_OP(ERR_OP), .ABORTED(ABORTED),
        .FL_ADDR(FL_ADDR), .FL_DQ_IN(FL_DQ_IN), .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE_N(FL_DQ_OE_N),
        .FL_CE_N(FL_CE_N), .FL_WE_N(FL_WE_N), .FL_OE_N(FL_OE_N), .FL_RP_N(FL_RP_N),
        .FL_READY_BUSY_N_OUT_N(FL_READY_BUSY_N_OUT_N));
    frwp_flash_model u_flash (.clk(CLK), .ce_n(FL_CE_N), .we_n(FL_WE_N), .oe_n(FL_OE_N),
        .rp_n(FL_RP_N), .vpp_ok(vpp_ok), .addr(FL_ADDR), .din(FL_DQ_OUT),
        .busy_len(busy_len), .dout(fl_dout), .ready_busy_n_out_n(FL_READY_BUSY_N_OUT_N));
    initial forever #10 CLK = ~CLK;
    task automatic stop_test();
        $display("Counts: %0d checks, %0d mismatches", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Ceiling well above five short tests
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic cmp(input string what, input logic [7:0] exp, got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic go(input logic [1:0] k, input logic [19:0] a, input logic [7:0] d);
        int n = 0;
        do @(posedge CLK); while (REQ_READY !== 1'b1 && ++n < 3000);
        OP_KIND <= k;
        REQ_ADDR <= a;
        REQ_DATA <= d;
        REQ_VALID <= 1'b1;
        @(posedge CLK);
        REQ_VALID <= 1'b0;
    endtask
    task automatic op(input logic [1:0] k, input logic [19:0] a, input logic [7:0] d, exp);
        int n = 0;
        go(k, a, d);
        do @(posedge CLK); while (DONE !== 1'b1 && ++n < 3000);
        cmp("done", 8'h01, {7'h00, DONE});
        cmp("result", exp, RESULT);
    endtask
    task automatic t_write();
        op(2'h0, 20'h00003, 8'h5A, 8'h80);
        cmp("err bits", 8'h00, {6'h00, ERR_SUPPLY, ERR_OP});
        op(2'h0, 20'h00004, 8'hA5, 8'h80);
        op(2'h3, 20'h00003, 8'h00, 8'h5A);
        op(2'h3, 20'h00004, 8'h00, 8'hA5);
        $display("t_write done");
    endtask
    task automatic t_erase();
        op(2'h1, 20'h00000, 8'h00, 8'h80);
        op(2'h3, 20'h00003, 8'h00, 8'hFF);
        op(2'h2, 20'h00000, 8'h00, 8'h80);
        $display("t_erase done");
    endtask
    task automatic t_fault();
        vpp_ok <= 1'b0;
        op(2'h0, 20'h00005, 8'h11, 8'h98);
        cmp("err bits", 8'h03, {6'h00, ERR_SUPPLY, ERR_OP});
        op(2'h1, 20'h00000, 8'h00, 8'hB8);
        vpp_ok <= 1'b1;
        op(2'h3, 20'h00005, 8'h00, 8'hFF);
        $display("t_fault done");
    endtask
    task automatic t_pd();
        PD_REQ <= 1'b1;
        repeat (6) @(posedge CLK);
        cmp("rp pin", 8'h00, {7'h00, FL_RP_N});
        PD_REQ <= 1'b0;
        op(2'h0, 20'h00006, 8'h3C, 8'h80);
        op(2'h3, 20'h00006, 8'h00, 8'h3C);
        $display("t_pd done");
    endtask
    task automatic t_abort();
        int n = 0;
        busy_len <= 8'hC8;
        go(2'h0, 20'h00007, 8'h77);
        do @(posedge CLK); while (FL_READY_BUSY_N_OUT_N !== 1'b0 && ++n < 500);
        RST <= 1'b1;
        busy_len <= 8'h0C;
        repeat (2) @(posedge CLK);
        cmp("busy in reset", 8'h00, {7'h00, FL_READY_BUSY_N_OUT_N});
        RST <= 1'b0;
        op(2'h0, 20'h00007, 8'h77, 8'h80);
        op(2'h3, 20'h00007, 8'h00, 8'h77);
        cmp("aborted", 8'h00, {7'h00, ABORTED});
        $display("t_abort done");
    endtask
    initial begin
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        t_write();
        t_erase();
        t_fault();
        t_pd();
        t_abort();
        stop_test();
    end
endmodule
